/* rtl/pfm_pkg.sv */
package pfm_pkg;

  // ************************************************************
  // sizes
  // ************************************************************
  localparam int PFM_NUM_PINS = 51;
  localparam int PFM_ADDR_W   = 8;
  localparam int PFM_DATA_W   = 8;
  localparam int PFM_BANKS    = 7;

  // ************************************************************
  // register map, one bank of eight pins per register except misc, a single register at 8'h40
  // ************************************************************
  localparam logic [7:0] PFM_OFS_DRIVE   = 8'h00;
  localparam logic [7:0] PFM_OFS_SLEW    = 8'h10;
  localparam logic [7:0] PFM_OFS_PULLUP  = 8'h20;
  localparam logic [7:0] PFM_OFS_PINSTAT = 8'h30;
  localparam logic [7:0] PFM_OFS_MISC    = 8'h40;
  localparam logic [7:0] PFM_BANK_MASK   = 8'hf0;

  // ************************************************************
  // misc register fields
  // ************************************************************
  localparam int PFM_MISC_IRQ_EN  = 0;
  localparam int PFM_MISC_USB_PU  = 1;
  localparam int PFM_MISC_IRQ_LVL = 2;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic [7:0] PFM_RST_BANK = 8'h00;
  localparam logic [7:0] PFM_RST_MISC = 8'h00;

  // ************************************************************
  // pin owner encoding
  // ************************************************************
  typedef enum logic [1:0] {
    PFM_OWN_PORT = 2'b00,
    PFM_OWN_FIRST_ALTERNATE_FUNCTION = 2'b01,
    PFM_OWN_SECOND_ALTERNATE_FUNCTION = 2'b10
  } pfm_owner_t;

endpackage : pfm_pkg

/* rtl/pfm_pin_cell.sv */
module pfm_pin_cell
  import pfm_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic port_dir,
  input  wire logic port_out,
  input  wire logic first_alternate_function_en,
  input  wire logic first_alternate_function_dir,
  input  wire logic first_alternate_function_out,
  input  wire logic second_alternate_function_en,
  input  wire logic second_alternate_function_dir,
  input  wire logic second_alternate_function_out,
  input  wire logic drive_hi,
  input  wire logic slew_lim,
  input  wire logic pullup_en,
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_drive_hi,
  output logic      pad_slew_lim,
  output logic      pad_pullup,
  output logic      in_val,
  output logic      owner_dir
);

  // ************************************************************
  // owner selection
  // ************************************************************
  pfm_owner_t owner;
  logic       sel_dir;
  logic       sel_out;
  logic       out_r;
  logic       oe_r;
  logic       dh_r;
  logic       sl_r;
  logic       pu_r;
  logic       in_r;

  assign owner = second_alternate_function_en ? PFM_OWN_SECOND_ALTERNATE_FUNCTION : (first_alternate_function_en ? PFM_OWN_FIRST_ALTERNATE_FUNCTION : PFM_OWN_PORT);

  always_comb begin
    case (owner)
      PFM_OWN_SECOND_ALTERNATE_FUNCTION: begin
        sel_dir = second_alternate_function_dir;
        sel_out = second_alternate_function_out;
      end
      PFM_OWN_FIRST_ALTERNATE_FUNCTION: begin
        sel_dir = first_alternate_function_dir;
        sel_out = first_alternate_function_out;
      end
      PFM_OWN_PORT: begin
        sel_dir = port_dir;
        sel_out = port_out;
      end
      default: begin
        sel_dir = 1'b0;
        sel_out = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // pad registers
  // ************************************************************
  // reset to input, no pullup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_r <= 1'b0;
      oe_r  <= 1'b0;
      dh_r  <= 1'b0;
      sl_r  <= 1'b0;
      pu_r  <= 1'b0;
      in_r  <= 1'b0;
    end else begin
      out_r <= sel_out;
      oe_r  <= sel_dir;
      dh_r  <= sel_dir & drive_hi;
      sl_r  <= sel_dir & slew_lim;
      pu_r  <= ~sel_dir & pullup_en;
      // input fed to every function; glitches on switch are accepted
      in_r  <= pad_in;
    end
  end

  assign pad_out      = out_r;
  assign pad_oe       = oe_r;
  assign pad_drive_hi = dh_r;
  assign pad_slew_lim = sl_r;
  assign pad_pullup   = pu_r;
  assign in_val       = in_r;
  assign owner_dir    = sel_dir;

endmodule // pfm_pin_cell

/* rtl/pfm_pin_mux.sv */
// The plain strobed port and the register addresses are this design's own decisions.
module pfm_pin_mux
  import pfm_pkg::*;
#(
  parameter int NPINS = PFM_NUM_PINS
) (
  input  wire logic                  MCLK,
  input  wire logic                  RSTN,
  input  wire logic [PFM_ADDR_W-1:0] ADDR,
  input  wire logic [PFM_DATA_W-1:0] WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [PFM_DATA_W-1:0] RDATA,
  input  wire logic [NPINS-1:0]      PORT_DIR,
  input  wire logic [NPINS-1:0]      PORT_OUT,
  input  wire logic [NPINS-1:0]      FIRST_ALTERNATE_FUNCTION_EN,
  input  wire logic [NPINS-1:0]      FIRST_ALTERNATE_FUNCTION_DIR,
  input  wire logic [NPINS-1:0]      FIRST_ALTERNATE_FUNCTION_OUT,
  input  wire logic [NPINS-1:0]      SECOND_ALTERNATE_FUNCTION_EN,
  input  wire logic [NPINS-1:0]      SECOND_ALTERNATE_FUNCTION_DIR,
  input  wire logic [NPINS-1:0]      SECOND_ALTERNATE_FUNCTION_OUT,
  output logic      [NPINS-1:0]      PIN_IN,
  input  wire logic [NPINS-1:0]      PAD_I,
  output logic      [NPINS-1:0]      PAD_O,
  output logic      [NPINS-1:0]      PAD_OE,
  output logic      [NPINS-1:0]      PAD_DRIVE_HI,
  output logic      [NPINS-1:0]      PAD_SLEW_LIM,
  output logic      [NPINS-1:0]      PAD_PULLUP,
  input  wire logic                  INT_PIN_I,
  output logic                       INT_REQ_LEVEL,
  output logic                       BRANCH_IF_INT_PIN_HIGH,
  output logic                       BRANCH_IF_INT_PIN_LOW,
  output logic                       TIMER_EXTERNAL_CLOCK_INPUT,
  output logic                       POSITIVE_LINE_PULLUP
);

  localparam int NREG = PFM_BANKS * 8;

  // ************************************************************
  // reset release
  // ************************************************************
  logic rst_s1_r;
  logic rst_n_r;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  logic [PFM_DATA_W-1:0] drive_r  [PFM_BANKS];
  logic [PFM_DATA_W-1:0] slew_r   [PFM_BANKS];
  logic [PFM_DATA_W-1:0] pullup_r [PFM_BANKS];
  logic [PFM_DATA_W-1:0] misc_r;
  logic [PFM_DATA_W-1:0] rdata_r;
  logic [PFM_DATA_W-1:0] rdata_nxt;
  logic [NREG-1:0]       drive_flat;
  logic [NREG-1:0]       slew_flat;
  logic [NREG-1:0]       pullup_flat;
  logic [NREG-1:0]       stat_flat;
  logic [NPINS-1:0]      in_vec;
  logic [7:0]            bank_base;
  logic [7:0]            bank_idx;
  logic                  bank_ok;
  logic                  irq_en;
  logic                  irq_lvl_r;

  function automatic logic [7:0] bank_of(input logic [7:0] a);
    return a & ~PFM_BANK_MASK;
  endfunction

  assign bank_base = ADDR & PFM_BANK_MASK;
  assign bank_idx  = bank_of(ADDR);
  assign bank_ok   = (bank_idx < 8'(PFM_BANKS));

  always_ff @(posedge MCLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      for (int b = 0; b < PFM_BANKS; b++) begin
        drive_r[b]  <= PFM_RST_BANK;
        slew_r[b]   <= PFM_RST_BANK;
        pullup_r[b] <= PFM_RST_BANK;
      end
      misc_r <= PFM_RST_MISC;
    end else if (WR) begin
      if (bank_ok && bank_base == PFM_OFS_DRIVE) begin
        drive_r[bank_idx[2:0]] <= WDATA;
      end
      if (bank_ok && bank_base == PFM_OFS_SLEW) begin
        slew_r[bank_idx[2:0]] <= WDATA;
      end
      if (bank_ok && bank_base == PFM_OFS_PULLUP) begin
        pullup_r[bank_idx[2:0]] <= WDATA;
      end
      if (ADDR == PFM_OFS_MISC) begin
        misc_r <= WDATA;
      end
    end
  end

  always_comb begin
    drive_flat  = '0;
    slew_flat   = '0;
    pullup_flat = '0;
    stat_flat   = '0;
    for (int b = 0; b < PFM_BANKS; b++) begin
      drive_flat[b*8 +: 8]  = drive_r[b];
      slew_flat[b*8 +: 8]   = slew_r[b];
      pullup_flat[b*8 +: 8] = pullup_r[b];
    end
    stat_flat[NPINS-1:0] = in_vec;
  end

  // unmapped addresses read zero
  always_comb begin
    rdata_nxt = '0;
    if (RD) begin
      if (bank_ok && bank_base == PFM_OFS_DRIVE) begin
        rdata_nxt = drive_flat[bank_idx[2:0]*8 +: 8];
      end else if (bank_ok && bank_base == PFM_OFS_SLEW) begin
        rdata_nxt = slew_flat[bank_idx[2:0]*8 +: 8];
      end else if (bank_ok && bank_base == PFM_OFS_PULLUP) begin
        rdata_nxt = pullup_flat[bank_idx[2:0]*8 +: 8];
      end else if (bank_ok && bank_base == PFM_OFS_PINSTAT) begin
        rdata_nxt = stat_flat[bank_idx[2:0]*8 +: 8];
      end else if (ADDR == PFM_OFS_MISC) begin
        rdata_nxt = {5'h00, irq_lvl_r, misc_r[PFM_MISC_USB_PU], misc_r[PFM_MISC_IRQ_EN]};
      end
    end
  end

  always_ff @(posedge MCLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign RDATA = rdata_r;

  // ************************************************************
  // pin cells
  // ************************************************************
  // one cell per shared pin
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    pfm_pin_cell u_cell (
      .clk          (MCLK),
      .rst_n        (rst_n_r),
      .port_dir     (PORT_DIR[i]),
      .port_out     (PORT_OUT[i]),
      .first_alternate_function_en      (FIRST_ALTERNATE_FUNCTION_EN[i]),
      .first_alternate_function_dir     (FIRST_ALTERNATE_FUNCTION_DIR[i]),
      .first_alternate_function_out     (FIRST_ALTERNATE_FUNCTION_OUT[i]),
      .second_alternate_function_en      (SECOND_ALTERNATE_FUNCTION_EN[i]),
      .second_alternate_function_dir     (SECOND_ALTERNATE_FUNCTION_DIR[i]),
      .second_alternate_function_out     (SECOND_ALTERNATE_FUNCTION_OUT[i]),
      .drive_hi     (drive_flat[i]),
      .slew_lim     (slew_flat[i]),
      .pullup_en    (pullup_flat[i]),
      .pad_in       (PAD_I[i]),
      .pad_out      (PAD_O[i]),
      .pad_oe       (PAD_OE[i]),
      .pad_drive_hi (PAD_DRIVE_HI[i]),
      .pad_slew_lim (PAD_SLEW_LIM[i]),
      .pad_pullup   (PAD_PULLUP[i]),
      .in_val       (in_vec[i]),
      .owner_dir    ()
    );
  end

  assign PIN_IN = in_vec;

  // ************************************************************
  // interrupt pin
  // ************************************************************
  assign irq_en = misc_r[PFM_MISC_IRQ_EN];

  // single registered copy; timer does its own synchronising
  always_ff @(posedge MCLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      irq_lvl_r <= 1'b0;
    end else begin
      irq_lvl_r <= INT_PIN_I;
    end
  end

  assign INT_REQ_LEVEL          = irq_en & irq_lvl_r;
  assign BRANCH_IF_INT_PIN_HIGH = irq_lvl_r;
  assign BRANCH_IF_INT_PIN_LOW  = ~irq_lvl_r;
  assign TIMER_EXTERNAL_CLOCK_INPUT = ~irq_en & irq_lvl_r;

  assign POSITIVE_LINE_PULLUP = misc_r[PFM_MISC_USB_PU];

endmodule // pfm_pin_mux

/* test/pfm_board.sv */
module pfm_board
  import pfm_pkg::*;
#(
  parameter int NPINS = PFM_NUM_PINS
) (
  input  wire logic             clk,
  input  wire logic [NPINS-1:0] pad_o,
  input  wire logic [NPINS-1:0] pad_oe,
  input  wire logic [NPINS-1:0] pad_pullup,
  input  wire logic [NPINS-1:0] ext_en,
  input  wire logic [NPINS-1:0] ext_val,
  output logic      [NPINS-1:0] pad_i
);
  // *****
  // board lines
  // *****
  // floating lines wander, so stale values never pass
  logic [NPINS-1:0] float_r = '0;
  always_ff @(posedge clk) float_r <= ~float_r;
  assign pad_i = pad_oe & pad_o | ~pad_oe & (ext_en & ext_val | ~ext_en & (pad_pullup | float_r));
endmodule // pfm_board

/* test/pfm_pin_mux_sva.sv */
module pfm_pin_mux_sva
  import pfm_pkg::*;
#(
  parameter int NPINS = PFM_NUM_PINS
) (
  input wire logic             MCLK,
  input wire logic             RSTN,
  input wire logic [7:0]       ADDR,
  input wire logic [7:0]       WDATA,
  input wire logic             WR,
  input wire logic [NPINS-1:0] PORT_DIR,
  input wire logic [NPINS-1:0] PORT_OUT,
  input wire logic [NPINS-1:0] FIRST_ALTERNATE_FUNCTION_EN,
  input wire logic [NPINS-1:0] FIRST_ALTERNATE_FUNCTION_DIR,
  input wire logic [NPINS-1:0] FIRST_ALTERNATE_FUNCTION_OUT,
  input wire logic [NPINS-1:0] SECOND_ALTERNATE_FUNCTION_EN,
  input wire logic [NPINS-1:0] SECOND_ALTERNATE_FUNCTION_DIR,
  input wire logic [NPINS-1:0] SECOND_ALTERNATE_FUNCTION_OUT,
  input wire logic [NPINS-1:0] PIN_IN,
  input wire logic [NPINS-1:0] PAD_I,
  input wire logic [NPINS-1:0] PAD_O,
  input wire logic [NPINS-1:0] PAD_OE,
  input wire logic [NPINS-1:0] PAD_DRIVE_HI,
  input wire logic [NPINS-1:0] PAD_PULLUP,
  input wire logic             INT_PIN_I,
  input wire logic             INT_REQ_LEVEL,
  input wire logic             BRANCH_IF_INT_PIN_HIGH,
  input wire logic             BRANCH_IF_INT_PIN_LOW,
  input wire logic             TIMER_EXTERNAL_CLOCK_INPUT,
  input wire logic             POSITIVE_LINE_PULLUP
);
  // *****
  // owner model
  // *****
  // internal reset trails RSTN, so checks wait for it
  logic [1:0] up_r;
  wire live = up_r == 2'h3;
  wire [NPINS-1:0] a1 = FIRST_ALTERNATE_FUNCTION_EN & ~SECOND_ALTERNATE_FUNCTION_EN;
  wire [NPINS-1:0] po = ~FIRST_ALTERNATE_FUNCTION_EN & ~SECOND_ALTERNATE_FUNCTION_EN;
  wire [NPINS-1:0] odir = SECOND_ALTERNATE_FUNCTION_EN & SECOND_ALTERNATE_FUNCTION_DIR | a1 & FIRST_ALTERNATE_FUNCTION_DIR | po & PORT_DIR;
  wire [NPINS-1:0] oout = SECOND_ALTERNATE_FUNCTION_EN & SECOND_ALTERNATE_FUNCTION_OUT | a1 & FIRST_ALTERNATE_FUNCTION_OUT | po & PORT_OUT;
  always_ff @(posedge MCLK or negedge RSTN)
    if (!RSTN) up_r <= 2'h0;
    else if (!live) up_r <= up_r + 2'h1;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  a_oe_owner: assert property (live |-> PAD_OE == $past(odir))
    else $error("pad enable not from owner");
  a_out_owner: assert property (live |-> (PAD_O & PAD_OE) == ($past(oout) & PAD_OE))
    else $error("pad value not from owner");
  a_drive_input: assert property (live |-> (PAD_DRIVE_HI & ~PAD_OE) == '0)
    else $error("drive on input pin");
  a_pull_output: assert property (live |-> (PAD_PULLUP & PAD_OE) == '0)
    else $error("pullup on output pin");
  a_reset_quiet: assert property (disable iff (1'b0) !RSTN |-> !(|PAD_OE) && !(|PAD_PULLUP))
    else $error("pad active in reset");
  a_branch_pin: assert property (live |-> BRANCH_IF_INT_PIN_HIGH == $past(INT_PIN_I)
    && BRANCH_IF_INT_PIN_LOW != BRANCH_IF_INT_PIN_HIGH)
    else $error("branch level wrong");
  a_irq_timer: assert property (live |-> (INT_REQ_LEVEL | TIMER_EXTERNAL_CLOCK_INPUT)
    == BRANCH_IF_INT_PIN_HIGH && !(INT_REQ_LEVEL && TIMER_EXTERNAL_CLOCK_INPUT))
    else $error("irq timer split wrong");
  a_usb_pullup: assert property (live && WR && ADDR == PFM_OFS_MISC |=>
    POSITIVE_LINE_PULLUP == $past(WDATA[PFM_MISC_USB_PU])) else $error("usb pullup wrong");
  a_pin_sample: assert property (live |-> PIN_IN == $past(PAD_I))
    else $error("pin input lost");
  c_second_alternate_function: cover property (SECOND_ALTERNATE_FUNCTION_EN[0] && FIRST_ALTERNATE_FUNCTION_EN[0]);
  c_pull: cover property (PAD_PULLUP != '0);
  c_usb: cover property (POSITIVE_LINE_PULLUP);
endmodule // pfm_pin_mux_sva

bind pfm_pin_mux pfm_pin_mux_sva #(.NPINS(NPINS)) chk (.MCLK, .RSTN, .ADDR, .WDATA, .WR,
  .PORT_DIR, .PORT_OUT, .FIRST_ALTERNATE_FUNCTION_EN, .FIRST_ALTERNATE_FUNCTION_DIR, .FIRST_ALTERNATE_FUNCTION_OUT, .SECOND_ALTERNATE_FUNCTION_EN, .SECOND_ALTERNATE_FUNCTION_DIR, .SECOND_ALTERNATE_FUNCTION_OUT,
  .PIN_IN, .PAD_I, .PAD_O, .PAD_OE, .PAD_DRIVE_HI, .PAD_PULLUP, .INT_PIN_I, .INT_REQ_LEVEL,
  .BRANCH_IF_INT_PIN_HIGH, .BRANCH_IF_INT_PIN_LOW, .TIMER_EXTERNAL_CLOCK_INPUT,
  .POSITIVE_LINE_PULLUP);

/* test/pfm_pin_mux_tb.sv */
module pfm_pin_mux_tb;
  import pfm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int N = PFM_NUM_PINS;
  localparam logic [N-1:0] PAT = 51'h2_aaaa_5555_f00f;
  logic MCLK = 0, RSTN = 1, WR = 0, RD = 0, INT_PIN_I = 0;
  logic [7:0] ADDR = '0, WDATA = '0, RDATA, rv;
  logic [N-1:0] PORT_DIR = '0, PORT_OUT = '0, FIRST_ALTERNATE_FUNCTION_EN = '0, FIRST_ALTERNATE_FUNCTION_DIR = '0, FIRST_ALTERNATE_FUNCTION_OUT = '0;
  logic [N-1:0] SECOND_ALTERNATE_FUNCTION_EN = '0, SECOND_ALTERNATE_FUNCTION_DIR = '0, SECOND_ALTERNATE_FUNCTION_OUT = '0, ext_en = '0, ext_val = '0;
  logic [N-1:0] PIN_IN, PAD_I, PAD_O, PAD_OE, PAD_DRIVE_HI, PAD_SLEW_LIM, PAD_PULLUP;
  logic INT_REQ_LEVEL, BRANCH_IF_INT_PIN_HIGH, BRANCH_IF_INT_PIN_LOW;
  logic TIMER_EXTERNAL_CLOCK_INPUT, POSITIVE_LINE_PULLUP;
  int errors = 0, cmp_count = 0;
  initial forever #4 MCLK = ~MCLK;
  pfm_pin_mux uut (.MCLK, .RSTN, .ADDR, .WDATA, .WR, .RD, .RDATA, .PORT_DIR, .PORT_OUT,
    .FIRST_ALTERNATE_FUNCTION_EN, .FIRST_ALTERNATE_FUNCTION_DIR, .FIRST_ALTERNATE_FUNCTION_OUT, .SECOND_ALTERNATE_FUNCTION_EN, .SECOND_ALTERNATE_FUNCTION_DIR, .SECOND_ALTERNATE_FUNCTION_OUT, .PIN_IN, .PAD_I, .PAD_O,
    .PAD_OE, .PAD_DRIVE_HI, .PAD_SLEW_LIM, .PAD_PULLUP, .INT_PIN_I, .INT_REQ_LEVEL,
    .BRANCH_IF_INT_PIN_HIGH, .BRANCH_IF_INT_PIN_LOW, .TIMER_EXTERNAL_CLOCK_INPUT,
    .POSITIVE_LINE_PULLUP);
  pfm_board brd (.clk(MCLK), .pad_o(PAD_O), .pad_oe(PAD_OE), .pad_pullup(PAD_PULLUP),
    .ext_en, .ext_val, .pad_i(PAD_I));
  // *****
  // helpers
  // *****
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    if (errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge MCLK);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input logic [7:0] a);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    // taken at the edge that closes that cycle, before it clears
    @(posedge MCLK);
    rv = RDATA;
  endtask
  // *****
  // scenarios
  // *****
  task t_port;
    chk(PAD_OE | PAD_PULLUP, 0);
    rd(PFM_OFS_PULLUP);
    chk(rv, 0);
    rd(8'h50);
    chk(rv, 0);
    PORT_DIR <= '1;
    PORT_OUT <= PAT;
    tick(3);
    chk(PAD_OE, {N{1'b1}});
    chk(PIN_IN, PAT);
    rd(PFM_OFS_PINSTAT + 8'h6);
    chk(rv, {5'h0, PAT[50:48]});
  endtask
  task t_prio;
    FIRST_ALTERNATE_FUNCTION_EN[0] <= 1'b1;
    FIRST_ALTERNATE_FUNCTION_DIR[0] <= 1'b1;
    tick(2);
    chk(PAD_O[0], 0);
    SECOND_ALTERNATE_FUNCTION_EN[0] <= 1'b1;
    ext_en[0] <= 1'b1;
    ext_val[0] <= 1'b1;
    tick(3);
    chk({PAD_OE[0], PIN_IN[0]}, 2'b01);
    // drop every sharer before the port takes over
    FIRST_ALTERNATE_FUNCTION_EN <= '0;
    SECOND_ALTERNATE_FUNCTION_EN <= '0;
    ext_en <= '0;
    tick(2);
    chk(PAD_O[0], 1);
  endtask
  task t_pads;
    wr(PFM_OFS_DRIVE, 8'hff);
    wr(PFM_OFS_SLEW, 8'h3c);
    wr(PFM_OFS_DRIVE + 8'h6, 8'hff);
    tick(2);
    chk({PAD_DRIVE_HI[7:0], PAD_SLEW_LIM[7:0]}, 16'hff3c);
    rd(PFM_OFS_DRIVE + 8'h6);
    chk(rv, 8'hff);
    PORT_DIR <= '0;
    wr(PFM_OFS_PULLUP, 8'ha5);
    tick(3);
    chk({PAD_DRIVE_HI[7:0], PAD_PULLUP[7:0]}, 16'h00a5);
    chk({PIN_IN[7], PIN_IN[5], PIN_IN[2], PIN_IN[0]}, 4'hf);
  endtask
  task t_irq;
    // interrupt enabled before the pin is driven high
    wr(PFM_OFS_MISC, 8'h01);
    INT_PIN_I <= 1'b1;
    tick(3);
    chk({INT_REQ_LEVEL, TIMER_EXTERNAL_CLOCK_INPUT, BRANCH_IF_INT_PIN_HIGH}, 3'b101);
    wr(PFM_OFS_MISC, 8'h02);
    tick(2);
    chk({INT_REQ_LEVEL, TIMER_EXTERNAL_CLOCK_INPUT, POSITIVE_LINE_PULLUP}, 3'b011);
    rd(PFM_OFS_MISC);
    chk(rv, 8'h06);
  endtask
  // mid-run reset after configuration
  task t_reset;
    PORT_DIR[15:8] <= 8'hff;
    tick(1);
    RSTN <= 1'b0;
    tick(2);
    chk(PAD_OE | PAD_PULLUP, 0);
    chk(POSITIVE_LINE_PULLUP, 0);
    RSTN <= 1'b1;
    tick(3);
    rd(PFM_OFS_PULLUP);
    chk(rv, 0);
    chk({PAD_OE[15:8], PAD_PULLUP[7:0]}, 16'hff00);
  endtask
  initial begin
    #100us;
    errors++;
    results();
  end
  initial begin
    RSTN <= 1'b0;
    tick(5);
    RSTN <= 1'b1;
    tick(3);
    t_port();
    t_prio();
    t_pads();
    t_irq();
    t_reset();
    results();
  end
endmodule // pfm_pin_mux_tb
